/* hdl/pmrc_pkg.sv */
/*
  pmrc_pkg: constants and types shared by the power-mode and reset sequencer.
  Assumes a single free-running 200 MHz clock that keeps running while the core
  oscillator it controls is stopped.
*/
package pmrc_pkg;

  // =====================================================================
  // timing
  localparam int unsigned CLK_MHZ           = 200;
  localparam int unsigned POR_TIME_MS       = 128;
  // least time, exact at this rate
  localparam int unsigned POR_CYCLES        = POR_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned OSC_SETTLE_CYCLES = 16;
  localparam int unsigned TMR_W             = 25;

  // =====================================================================
  // wake vectors
  localparam logic [15:0] VEC_INTERVAL = 16'h0053;
  localparam logic [15:0] VEC_SERIAL   = 16'h003b;
  localparam logic [15:0] VEC_EXT_ZERO = 16'h0003;

  // =====================================================================
  // pin widths and reset levels
  localparam int unsigned PORT_W      = 32;
  localparam int unsigned DAC_W       = 24;
  localparam logic [31:0] PORT_RESET  = 32'hffff_ffff;
  localparam logic [23:0] DAC_RESET   = 24'h00_0000;

  // =====================================================================
  // states and wake sources
  typedef enum logic [2:0] {
    PMRC_RESET    = 3'b000,
    PMRC_POR_WAIT = 3'b001,
    PMRC_NORMAL   = 3'b010,
    PMRC_IDLE     = 3'b011,
    PMRC_PDOWN    = 3'b100,
    PMRC_OSC_WAIT = 3'b101
  } pmrc_state_type;

  typedef enum logic [1:0] {
    WAKE_NONE     = 2'b00,
    WAKE_EXT_ZERO = 2'b01,
    WAKE_SERIAL   = 2'b10,
    WAKE_INTERVAL = 2'b11
  } pmrc_wake_type;

endpackage

/* hdl/pmrc_tmr_if.sv */
/*
  pmrc_tmr_if: start/load/done bundle between the sequencer and its timer.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface pmrc_tmr_if;
  logic                      start;
  logic [pmrc_pkg::TMR_W-1:0] load;
  logic                      done;

  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface

`default_nettype wire

/* hdl/pmrc_timer.sv */
/*
  pmrc_timer: one-shot down counter; done pulses exactly load+1 cycles after the start pulse.
  Assumes load is at least one and start is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module pmrc_timer (
  input  wire logic clk_i,
  input  wire logic rst_i,
  pmrc_tmr_if.tmr   tif
);

  typedef struct packed {
    logic                       busy;
    logic [pmrc_pkg::TMR_W-1:0] cnt;
    logic                       done;
  } pmrc_tmr_state_type;

  pmrc_tmr_state_type q;
  pmrc_tmr_state_type d;

  // =====================================================================
  // count down
  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    if (tif.start)
    begin
      d.busy = 1'b1;
      d.cnt  = tif.load;
    end
    else if (q.busy)
    begin
      if (q.cnt == pmrc_pkg::TMR_W'(1))
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      d.cnt = q.cnt - pmrc_pkg::TMR_W'(1);
    end
  end

  // sync reset to idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign tif.done = q.done;

endmodule

`default_nettype wire

/* hdl/pmrc_top.sv */
/*
  pmrc_top: power-mode and reset sequencer of a small microcontroller.
  Assumes clk_i never stops; osc_en_o gates the core oscillator elsewhere.
  Supply comparators and the reset pin are asynchronous and synchronised here;
  request and interrupt inputs come from logic on clk_i.
*/
// What this block does
// [RL1] software request moves normal operation into idle or full power-down
// [RL2] idle keeps oscillator running, gates clock to the core only
// [RL3] idle keeps peripheral clocks running
// [RL4] idle holds port and converter outputs at their entry values
// [RL5] idle ends on any enabled interrupt or hardware reset
// [RL6] power-down stops oscillator and all peripheral clocks
// [RL7] power-down holds port levels, converter output goes high impedance
// [RL8] reset pin during power-down resets all and restarts at reset vector
// [RL9] supply cycling resets all, execution starts about 128 ms later
// [RL10] interval counter interrupt ends power-down and is serviced
// [RL11] return from wake routine resumes after the power-down instruction
// [RL12] serial interrupt wakes only with serial wake enable set
// [RL13] external interrupt zero wakes only with its wake enable set
// [RL14] below upper supply threshold hold reset, then 128 ms timer
// [RL15] falling supply keeps reset until below the 1 V threshold
// [RL16] wake service pushes pc and loads the source's vector
// [RL17] other sources never wake power-down; oscillator restarts before service
`timescale 1ns/1ps
`default_nettype none

module pmrc_top #(
  parameter int unsigned POR_CYCLES = pmrc_pkg::POR_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        supply_above_hi_i,
  input  wire logic        supply_above_lo_i,
  input  wire logic        idle_req_i,
  input  wire logic        pdown_req_i,
  input  wire logic [15:0] next_pc_i,
  input  wire logic        interrupt_return_i,
  input  wire logic        any_enabled_irq_i,
  input  wire logic        serial_wake_enable_i,
  input  wire logic        ext_int_wake_enable_i,
  input  wire logic        interval_counter_irq_i,
  input  wire logic        two_wire_irq_i,
  input  wire logic        serial_periph_irq_i,
  input  wire logic        ext_int_zero_flag_i,
  input  wire logic [31:0] port_i,
  input  wire logic [23:0] dac_i,
  output logic             chip_reset_o,
  output logic             core_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             osc_en_o,
  output logic [31:0]      port_o,
  output logic [23:0]      dac_o,
  output logic             dac_oe_o,
  output logic             push_pc_o,
  output logic [15:0]      pushed_pc_o,
  output logic             vector_load_o,
  output logic [15:0]      vector_o,
  output logic             resume_load_o,
  output logic [15:0]      resume_pc_o
);

  typedef struct packed {
    pmrc_pkg::pmrc_state_type   state;
    pmrc_pkg::pmrc_wake_type    wake;
    logic                       por_pend;
    logic                       in_isr;
    logic [15:0]                ret_pc;
    logic [1:0]                 pin_s;
    logic [1:0]                 hi_s;
    logic [1:0]                 lo_s;
    logic                       rst;
    logic                       core_en;
    logic                       per_en;
    logic                       osc_en;
    logic [31:0]                port;
    logic [23:0]                dac;
    logic                       dac_oe;
    logic                       push;
    logic                       vec_ld;
    logic [15:0]                vec;
    logic                       res_ld;
    logic [15:0]                res_pc;
    logic                       t_start;
    logic [pmrc_pkg::TMR_W-1:0] t_load;
  } pmrc_top_state_type;

  pmrc_top_state_type q;
  pmrc_top_state_type d;
  pmrc_tmr_if         tif ();

  logic wk_ext;
  logic wk_ser;
  logic wk_tic;

  // =====================================================================
  // wake qualification
  assign wk_ext = ext_int_zero_flag_i & ext_int_wake_enable_i;                   // RL13
  assign wk_ser = (two_wire_irq_i | serial_periph_irq_i) & serial_wake_enable_i; // RL12
  assign wk_tic = interval_counter_irq_i;                                        // RL10

  // =====================================================================
  // sequencer next state
  always_comb
  begin
    d         = q;
    d.pin_s   = {q.pin_s[0], reset_pin_n_i};
    d.hi_s    = {q.hi_s[0], supply_above_hi_i};
    d.lo_s    = {q.lo_s[0], supply_above_lo_i};
    d.push    = 1'b0;
    d.vec_ld  = 1'b0;
    d.res_ld  = 1'b0;
    d.t_start = 1'b0;
    case (q.state)
      pmrc_pkg::PMRC_RESET:
      begin
        if (!q.pin_s[1])
          d.state = pmrc_pkg::PMRC_RESET;
        else if (!q.por_pend)
        begin
          d.state = pmrc_pkg::PMRC_NORMAL;                         // RL8
          d.rst   = 1'b0;
        end
        else if (q.hi_s[1])
        begin
          // supply has crossed the upper threshold: run the settle timer
          d.state   = pmrc_pkg::PMRC_POR_WAIT;                     // RL14
          d.t_start = 1'b1;
          d.t_load  = pmrc_pkg::TMR_W'(POR_CYCLES);
        end
      end
      pmrc_pkg::PMRC_POR_WAIT:
      begin
        if (!q.hi_s[1])
          d.state = pmrc_pkg::PMRC_RESET;                          // RL14
        else if (tif.done)
        begin
          d.state    = pmrc_pkg::PMRC_NORMAL;                      // RL9
          d.por_pend = 1'b0;
          d.rst      = 1'b0;
        end
      end
      pmrc_pkg::PMRC_NORMAL:
      begin
        d.port   = port_i;
        d.dac    = dac_i;
        d.dac_oe = 1'b1;
        if (interrupt_return_i && q.in_isr)
        begin
          d.res_ld = 1'b1;                                         // RL11
          d.res_pc = q.ret_pc;
          d.in_isr = 1'b0;
        end
        if (pdown_req_i)
        begin
          // pins freeze at their last driven value, converter floats
          d.state   = pmrc_pkg::PMRC_PDOWN;                        // RL1
          d.ret_pc  = next_pc_i;
          d.core_en = 1'b0;
          d.per_en  = 1'b0;                                        // RL6
          d.osc_en  = 1'b0;
          d.port    = q.port;                                      // RL7
          d.dac     = q.dac;
          d.dac_oe  = 1'b0;
        end
        else if (idle_req_i)
        begin
          d.state   = pmrc_pkg::PMRC_IDLE;                         // RL1
          d.core_en = 1'b0;                                        // RL2
          d.port    = q.port;                                      // RL4
          d.dac     = q.dac;
        end
      end
      pmrc_pkg::PMRC_IDLE:
      begin
        // peripherals and oscillator untouched while idle          // RL3
        if (any_enabled_irq_i)
        begin
          d.state   = pmrc_pkg::PMRC_NORMAL;                       // RL5
          d.core_en = 1'b1;
        end
      end
      pmrc_pkg::PMRC_PDOWN:
      begin
        // apart from reset, only the three qualified sources end power-down
        if (wk_ext || wk_ser || wk_tic)                            // RL17
        begin
          d.state   = pmrc_pkg::PMRC_OSC_WAIT;
          d.osc_en  = 1'b1;
          d.t_start = 1'b1;
          d.t_load  = pmrc_pkg::TMR_W'(pmrc_pkg::OSC_SETTLE_CYCLES);
          if (wk_ext)
            d.wake = pmrc_pkg::WAKE_EXT_ZERO;
          else if (wk_ser)
            d.wake = pmrc_pkg::WAKE_SERIAL;
          else
            d.wake = pmrc_pkg::WAKE_INTERVAL;
        end
      end
      pmrc_pkg::PMRC_OSC_WAIT:
      begin
        // core stays stopped until the oscillator has settled
        if (tif.done)                                              // RL17
        begin
          d.state   = pmrc_pkg::PMRC_NORMAL;
          d.core_en = 1'b1;
          d.per_en  = 1'b1;
          d.dac_oe  = 1'b1;
          d.push    = 1'b1;                                        // RL16
          d.vec_ld  = 1'b1;
          d.in_isr  = 1'b1;
          case (q.wake)
            pmrc_pkg::WAKE_EXT_ZERO: d.vec = pmrc_pkg::VEC_EXT_ZERO;
            pmrc_pkg::WAKE_SERIAL:   d.vec = pmrc_pkg::VEC_SERIAL;
            default:                 d.vec = pmrc_pkg::VEC_INTERVAL;
          endcase
        end
      end
      default:
        d.state = pmrc_pkg::PMRC_RESET;
    endcase
    // reset sources override every state; low supply beats the pin
    if (!q.lo_s[1] || !q.pin_s[1])
    begin
      d.state   = pmrc_pkg::PMRC_RESET;                            // RL8
      d.rst     = 1'b1;
      d.core_en = 1'b1;
      d.per_en  = 1'b1;
      d.osc_en  = 1'b1;
      d.port    = pmrc_pkg::PORT_RESET;
      d.dac     = pmrc_pkg::DAC_RESET;
      d.dac_oe  = 1'b0;
      d.in_isr  = 1'b0;
      d.push    = 1'b0;
      d.vec_ld  = 1'b0;
      d.res_ld  = 1'b0;
      d.t_start = 1'b0;
      if (!q.lo_s[1])
        d.por_pend = 1'b1;                                         // RL15
    end
  end

  // =====================================================================
  // state register; comparators read low at reset, so POR runs first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q          <= '0;
      q.state    <= pmrc_pkg::PMRC_RESET;
      q.por_pend <= 1'b1;
      q.rst      <= 1'b1;
      q.core_en  <= 1'b1;
      q.per_en   <= 1'b1;
      q.osc_en   <= 1'b1;
      q.port     <= pmrc_pkg::PORT_RESET;
    end
    else
      q <= d;
  end

  pmrc_timer u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tif   (tif.tmr)
  );

  assign tif.start       = q.t_start;
  assign tif.load        = q.t_load;
  assign chip_reset_o    = q.rst;
  assign core_clk_en_o   = q.core_en;
  assign periph_clk_en_o = q.per_en;
  assign osc_en_o        = q.osc_en;
  assign port_o          = q.port;
  assign dac_o           = q.dac;
  assign dac_oe_o        = q.dac_oe;
  assign push_pc_o       = q.push;
  assign pushed_pc_o     = q.ret_pc;
  assign vector_load_o   = q.vec_ld;
  assign vector_o        = q.vec;
  assign resume_load_o   = q.res_ld;
  assign resume_pc_o     = q.res_pc;

  // =====================================================================
  // checks
  a_idle_core_gated: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    q.state == pmrc_pkg::PMRC_IDLE |-> !core_clk_en_o && periph_clk_en_o && osc_en_o)
    else $error("idle clocks wrong");

  a_idle_pins_held: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
    q.state == pmrc_pkg::PMRC_IDLE && $past(q.state) == pmrc_pkg::PMRC_IDLE
      |-> $stable(port_o) && $stable(dac_o))
    else $error("pins moved in idle");

  a_pdown_all_off: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    q.state == pmrc_pkg::PMRC_PDOWN |-> !osc_en_o && !periph_clk_en_o && !dac_oe_o
      && $stable(port_o))
    else $error("power-down outputs wrong");

  a_pdown_entry: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    q.state == pmrc_pkg::PMRC_NORMAL && pdown_req_i && q.lo_s[1] && q.pin_s[1]
      |=> q.state == pmrc_pkg::PMRC_PDOWN && pushed_pc_o == $past(next_pc_i))
    else $error("power-down not entered");

  a_idle_exit: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
    q.state == pmrc_pkg::PMRC_IDLE && any_enabled_irq_i && q.lo_s[1] && q.pin_s[1]
      |=> q.state == pmrc_pkg::PMRC_NORMAL && core_clk_en_o)
    else $error("idle not left");

  a_pin_reset_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    !q.pin_s[1] |=> chip_reset_o && q.state == pmrc_pkg::PMRC_RESET)
    else $error("reset pin ignored");

  a_low_supply_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
    !q.lo_s[1] |=> chip_reset_o && q.por_pend)
    else $error("low supply ignored");

  a_no_stray_wake: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
    q.state == pmrc_pkg::PMRC_PDOWN && !wk_ext && !wk_ser && !wk_tic
      && q.lo_s[1] && q.pin_s[1] |=> q.state == pmrc_pkg::PMRC_PDOWN)
    else $error("stray wake");

  a_wake_vector: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    vector_load_o |-> push_pc_o && osc_en_o && $past(osc_en_o, 16)
      && (vector_o == pmrc_pkg::VEC_EXT_ZERO || vector_o == pmrc_pkg::VEC_SERIAL
      || vector_o == pmrc_pkg::VEC_INTERVAL))
    else $error("bad wake vector");

  a_wake_latency: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
    q.state == pmrc_pkg::PMRC_PDOWN && wk_tic && !wk_ext && !wk_ser
      && q.lo_s[1] && q.pin_s[1]
      |-> ##19 vector_load_o && vector_o == pmrc_pkg::VEC_INTERVAL)
    else $error("interval wake late");

  a_resume_pc: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
    resume_load_o |-> resume_pc_o == pushed_pc_o && !q.in_isr)
    else $error("resume pc wrong");

endmodule

`default_nettype wire

/* sim/tb_top.sv */
/*
  tb_top: self-checking bench for the power-mode and reset sequencer.
  Assumes pmrc_top as declared in hdl/, run with a short power-on count.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // =====================================================================
  // design hookup
  localparam int unsigned POR_N = 20; // short stand-in for 128 ms
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pin_n = 1'b1;
  logic        sup_hi = 1'b1;
  logic        sup_lo = 1'b1;
  logic        idle_req = 1'b0;
  logic        pdown_req = 1'b0;
  logic [15:0] next_pc = 16'h0000;
  logic        iret = 1'b0;
  logic        any_irq = 1'b0;
  logic        ser_en = 1'b0;
  logic        ext_en = 1'b0;
  logic        tic_irq = 1'b0;
  logic        tw_irq = 1'b0;
  logic        spi_irq = 1'b0;
  logic        ext_flag = 1'b0;
  logic [31:0] port_in = 32'h0000_0000;
  logic [23:0] dac_in = 24'h00_0000;
  logic        chip_reset_o, core_clk_en_o, periph_clk_en_o, osc_en_o, dac_oe_o;
  logic        push_pc_o, vector_load_o, resume_load_o;
  logic [31:0] port_o;
  logic [23:0] dac_o;
  logic [15:0] pushed_pc_o, vector_o, resume_pc_o;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;

  pmrc_top #(.POR_CYCLES(POR_N)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(pin_n),
    .supply_above_hi_i(sup_hi), .supply_above_lo_i(sup_lo),
    .idle_req_i(idle_req), .pdown_req_i(pdown_req), .next_pc_i(next_pc),
    .interrupt_return_i(iret), .any_enabled_irq_i(any_irq),
    .serial_wake_enable_i(ser_en), .ext_int_wake_enable_i(ext_en),
    .interval_counter_irq_i(tic_irq), .two_wire_irq_i(tw_irq),
    .serial_periph_irq_i(spi_irq), .ext_int_zero_flag_i(ext_flag),
    .port_i(port_in), .dac_i(dac_in), .chip_reset_o(chip_reset_o),
    .core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .osc_en_o(osc_en_o), .port_o(port_o), .dac_o(dac_o), .dac_oe_o(dac_oe_o),
    .push_pc_o(push_pc_o), .pushed_pc_o(pushed_pc_o), .vector_load_o(vector_load_o),
    .vector_o(vector_o), .resume_load_o(resume_load_o), .resume_pc_o(resume_pc_o)
  );

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // =====================================================================
  // helpers
  task tick;
    @(posedge clk_i);
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // counts edges until chip reset drops; capped so a stuck reset cannot hang
  task wait_release;
    n = 0;
    while (chip_reset_o !== 1'b0 && n < 100)
    begin
      tick;
      #1;
      n++;
    end
  endtask

  task pdown(input logic [15:0] a);
    tick;
    next_pc <= a;
    pdown_req <= 1'b1;
    tick;
    pdown_req <= 1'b0;
    #1;
  endtask

  task test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      test_done;
    end
  end

  // =====================================================================
  // main sequence
  initial
  begin
    repeat (4) tick;
    rst_i <= 1'b0;
    #1;
    chk("reset_held", chip_reset_o, 1);
    chk("port_default", port_o, 32'hffff_ffff);
    chk("dac_off", dac_oe_o, 0);
    wait_release;
    chk("por_wait", n >= POR_N && n <= POR_N + 6, 1);
    // idle keeps peripherals and oscillator, holds pins
    tick;
    port_in <= 32'hcafe_0001;
    dac_in <= 24'h12_3456;
    tick;
    tick;
    idle_req <= 1'b1;
    tick;
    idle_req <= 1'b0;
    #1;
    chk("idle_core", core_clk_en_o, 0);
    chk("idle_osc", osc_en_o, 1);
    chk("idle_periph", periph_clk_en_o, 1);
    tick;
    port_in <= 32'h0bad_0002;
    dac_in <= 24'h65_4321;
    repeat (3) tick;
    #1;
    chk("idle_port", port_o, 32'hcafe_0001);
    chk("idle_dac", dac_o, 24'h12_3456);
    tick;
    any_irq <= 1'b1;
    tick;
    any_irq <= 1'b0;
    #1;
    chk("idle_exit", core_clk_en_o, 1);
    // each wake source in turn; 1 and 2 share the serial vector
    for (int k = 0; k < 4; k++)
    begin
      pdown(16'h1230 + k[15:0]);
      chk("pd_osc", osc_en_o, 0);
      chk("pd_periph", periph_clk_en_o, 0);
      chk("pd_core", core_clk_en_o, 0);
      chk("pd_dac_oe", dac_oe_o, 0);
      tick;
      port_in <= 32'h5555_aaaa;
      tw_irq <= 1'b1;
      spi_irq <= 1'b1;
      ext_flag <= 1'b1;
      any_irq <= 1'b1;
      repeat (30) tick;
      #1;
      chk("pd_no_wake", osc_en_o, 0);
      chk("pd_port", port_o, 32'h0bad_0002);
      tick;
      tw_irq <= 1'b0;
      spi_irq <= 1'b0;
      ext_flag <= 1'b0;
      any_irq <= 1'b0;
      port_in <= 32'h0bad_0002;
      tick;
      case (k)
        0: begin ext_en <= 1'b1; ext_flag <= 1'b1; end
        1: begin ser_en <= 1'b1; tw_irq <= 1'b1; end
        2: begin ser_en <= 1'b1; spi_irq <= 1'b1; end
        default: tic_irq <= 1'b1;
      endcase
      tick;
      #1;
      chk("wake_osc", osc_en_o, 1);
      chk("wake_core_off", core_clk_en_o, 0);
      n = 0;
      while (vector_load_o !== 1'b1 && n < 40)
      begin
        tick;
        #1;
        n++;
      end
      chk("settle", n, 18);
      chk("vector", vector_o, k == 0 ? 16'h0003 : k == 3 ? 16'h0053 : 16'h003b);
      chk("push", push_pc_o, 1);
      chk("pushed_pc", pushed_pc_o, 16'h1230 + k);
      chk("wake_core", core_clk_en_o, 1);
      chk("wake_dac_oe", dac_oe_o, 1);
      tick;
      ext_en <= 1'b0;
      ser_en <= 1'b0;
      ext_flag <= 1'b0;
      tw_irq <= 1'b0;
      spi_irq <= 1'b0;
      tic_irq <= 1'b0;
      repeat (2)
      begin
        tick;
        iret <= 1'b1;
        tick;
        iret <= 1'b0;
        #1;
        chk("resume_pc", resume_pc_o, 16'h1230 + k);
        chk("resume_once", resume_load_o, n == 18);
        n = 0;
      end
    end
    // reset pin while powered down: defaults, no long wait
    pdown(16'h4444);
    tick;
    pin_n <= 1'b0;
    repeat (4) tick;
    #1;
    chk("pin_reset", chip_reset_o, 1);
    chk("pin_port", port_o, 32'hffff_ffff);
    chk("pin_dac_oe", dac_oe_o, 0);
    tick;
    pin_n <= 1'b1;
    wait_release;
    chk("pin_release", n <= 6, 1);
    chk("pin_core", core_clk_en_o, 1);
    // supply collapse, then a slow climb through the upper threshold
    tick;
    sup_lo <= 1'b0;
    sup_hi <= 1'b0;
    repeat (4) tick;
    #1;
    chk("brownout", chip_reset_o, 1);
    tick;
    sup_lo <= 1'b1;
    repeat (40) tick;
    #1;
    chk("below_hi", chip_reset_o, 1);
    tick;
    sup_hi <= 1'b1;
    wait_release;
    chk("power_cycle", n >= POR_N && n <= POR_N + 6, 1);
    chk("power_port", port_o, 32'hffff_ffff);
    test_done;
  end
endmodule

`default_nettype wire
